// File: src/epi_top.sv
// Contract
// - Pin activity requests even when driven out
// - Input two is edge sensed only
// - Level mode requests while pin stays low; masked while power_down is high
// - Edges on zero and one need I/O clock
// - Level and input two edge work clockless
// - Level wake sampled twice on watchdog tick
// - Level gone after start-up: wake, no request
// - Request needs global and own enable
// - Sample pins before edge detection
// - Input one sense field encoding
// - Input zero sense field encoding
// - Input two bit selects falling or rising
// - Input two edges caught above 50 ns
// - Input one enable bit 7, own vector
// - Zero enable bit 6, two bit 5
// - Event sets flag; service or one clears
// - Level mode flags read as cleared
`include "epi_consts.svh"

module epi_top
    import epi_pkg::*;
#(
    parameter int unsigned STARTUP_CYCLES = 1000
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] ext_req_pin,
    input wire logic global_int_enable,
    input wire logic [2:0] vector_ack,
    input wire logic io_clk_stopped,
    input wire logic power_down,
    output logic [2:0] irq_request,
    output logic wake_up
);

    localparam logic [15:0] WDT_LAST = 16'(`EPI_WDT_CYCLES - 1);
    localparam logic [15:0] START_LAST = 16'(STARTUP_CYCLES - 1);

    logic [3:0] sense_bits;
    logic sense_two_edge;
    logic [2:0] enables;
    logic [2:0] flags;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [2:0] pin_prev;
    logic [2:0] trig;
    logic [1:0] level_mode;
    logic [1:0] level_low;
    logic [2:0] clear_req;
    logic wr_access;
    logic flag_write;
    logic mapped;
    logic [31:0] next_rdata;
    logic [15:0] wdt_cnt;
    logic wdt_tick;
    logic [15:0] start_cnt;
    epi_wake_e wake_state;
    logic level_wake_cond;
    logic next_wake;

    // The slave never stalls, so every access phase completes in one cycle.
    assign pready = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign flag_write = wr_access && (paddr == `EPI_OFF_FLAGS);

    // Address decode for the error answer; the read mux decodes paddr itself.
    always_comb
    begin
        case (paddr)
            `EPI_OFF_SENSE_BITS: mapped = 1'b1;
            `EPI_OFF_STATUS_SENSE: mapped = 1'b1;
            `EPI_OFF_ENABLES: mapped = 1'b1;
            `EPI_OFF_FLAGS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Unmapped addresses answer with an error in the access phase.
    assign pslverr = psel && penable && !mapped;

    // Read data is built here and captured in the setup phase.
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (paddr)
            `EPI_OFF_SENSE_BITS: next_rdata[3:0] = sense_bits;
            `EPI_OFF_STATUS_SENSE: next_rdata[`EPI_SENSE_TWO_BIT] = sense_two_edge;
            `EPI_OFF_ENABLES:
            begin
                next_rdata[`EPI_BIT_REQ_ONE] = enables[1];
                next_rdata[`EPI_BIT_REQ_ZERO] = enables[0];
                next_rdata[`EPI_BIT_REQ_TWO] = enables[2];
            end
            `EPI_OFF_FLAGS:
            begin
                next_rdata[`EPI_BIT_REQ_ONE] = flags[1];
                next_rdata[`EPI_BIT_REQ_ZERO] = flags[0];
                next_rdata[`EPI_BIT_REQ_TWO] = flags[2];
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Registering read data in setup keeps prdata off any combinational path.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= next_rdata;
    end

    // Sense fields for inputs zero and one.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            sense_bits <= `EPI_RESET_SENSE;
        else if (wr_access && paddr == `EPI_OFF_SENSE_BITS)
            sense_bits <= pwdata[3:0];
    end

    // Edge select for input two; the only sense choice it has.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            sense_two_edge <= 1'b0;
        else if (wr_access && paddr == `EPI_OFF_STATUS_SENSE)
            sense_two_edge <= pwdata[`EPI_SENSE_TWO_BIT];
    end

    // Per-input enables, each at its own bit.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            enables <= `EPI_RESET_ENABLES;
        else if (wr_access && paddr == `EPI_OFF_ENABLES)
        begin
            enables[1] <= pwdata[`EPI_BIT_REQ_ONE];
            enables[0] <= pwdata[`EPI_BIT_REQ_ZERO];
            enables[2] <= pwdata[`EPI_BIT_REQ_TWO];
        end
    end

    // Two-stage synchroniser; the pin is read whatever its direction.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pin_meta <= 3'h7;
            pin_sync <= 3'h7;
        end
        else
        begin
            pin_meta <= ext_req_pin;
            pin_sync <= pin_meta;
        end
    end

    // Previous sample; inputs zero and one freeze while the I/O clock is stopped.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            pin_prev <= 3'h7;
        else
        begin
            if (!io_clk_stopped)
                pin_prev[1:0] <= pin_sync[1:0];
            pin_prev[2] <= pin_sync[2];
        end
    end

    // Edge and change detection for the two synchronous inputs.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync_in
            epi_sense_t mode;
            logic hit;
            assign mode = sense_bits[2 * gi + 1 -: 2];
            assign level_mode[gi] = (mode == `EPI_MODE_LOW);
            assign level_low[gi] = level_mode[gi] && !pin_sync[gi];
            always_comb
            begin
                if (io_clk_stopped)
                    hit = 1'b0;
                else
                begin
                    case (mode)
                        `EPI_MODE_ANY: hit = pin_sync[gi] ^ pin_prev[gi];
                        `EPI_MODE_FALL: hit = pin_prev[gi] && !pin_sync[gi];
                        `EPI_MODE_RISE: hit = !pin_prev[gi] && pin_sync[gi];
                        default: hit = 1'b0;
                    endcase
                end
            end
            // Every bit of trig is driven continuously, so no bit mixes driver kinds.
            assign trig[gi] = hit;
        end
    endgenerate

    // Input two is edge only; a 50 ns pulse spans five clocks, so it is seen.
    assign trig[2] = sense_two_edge ? (!pin_prev[2] && pin_sync[2])
                                    : (pin_prev[2] && !pin_sync[2]);

    // Clears come from the serviced vector or a one written to the flag.
    assign clear_req[0] = vector_ack[0] || (flag_write && pwdata[`EPI_BIT_REQ_ZERO]);
    assign clear_req[1] = vector_ack[1] || (flag_write && pwdata[`EPI_BIT_REQ_ONE]);
    assign clear_req[2] = vector_ack[2] || (flag_write && pwdata[`EPI_BIT_REQ_TWO]);

    // Sticky flags: a new event wins over a clear in the same cycle.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            flags <= 3'h0;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (level_mode[i])
                    flags[i] <= 1'b0;
                else
                    flags[i] <= trig[i] || (flags[i] && !clear_req[i]);
            end
            flags[2] <= trig[2] || (flags[2] && !clear_req[2]);
        end
    end

    // Level requests are held back while power_down is high, whatever the wake sequence does.
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            irq_request[i] = global_int_enable && enables[i]
                && (level_mode[i] ? (level_low[i] && !power_down) : flags[i]);
        end
        irq_request[2] = global_int_enable && enables[2] && flags[2];
    end

    // Watchdog oscillator stand-in: a one-cycle tick every microsecond.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            wdt_cnt <= 16'h0000;
        else if (wdt_cnt == WDT_LAST)
            wdt_cnt <= 16'h0000;
        else
            wdt_cnt <= wdt_cnt + 16'h0001;
    end

    assign wdt_tick = (wdt_cnt == WDT_LAST);
    assign level_wake_cond = (level_low[0] && enables[0]) || (level_low[1] && enables[1]);

    // Two consecutive low samples start the start-up count; noise shorter
    // than a tick period is ignored, which is the point of double sampling.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            wake_state <= WK_IDLE;
        else if (!power_down)
            wake_state <= WK_IDLE;
        else
        begin
            case (wake_state)
                WK_IDLE:
                    if (wdt_tick && level_wake_cond)
                        wake_state <= WK_FIRST;
                WK_FIRST:
                    if (wdt_tick)
                        wake_state <= level_wake_cond ? WK_STARTUP : WK_IDLE;
                WK_STARTUP:
                    if (start_cnt == START_LAST)
                        wake_state <= WK_IDLE;
                default: wake_state <= WK_IDLE;
            endcase
        end
    end

    // Start-up timer; the level need not persist through it.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            start_cnt <= 16'h0000;
        else if (wake_state != WK_STARTUP)
            start_cnt <= 16'h0000;
        else
            start_cnt <= start_cnt + 16'h0001;
    end

    // Wake pulse: end of start-up, or an enabled edge on input two in power-down.
    assign next_wake = power_down && ((wake_state == WK_STARTUP && start_cnt == START_LAST)
        || (trig[2] && enables[2]));

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            wake_up <= 1'b0;
        else
            wake_up <= next_wake;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Checks kept beside the logic they guard.
    flag_set_a: assert property (trig[0] && !level_mode[0] |=> flags[0])
        else $error("flag zero not set after event");

    flag_level_a: assert property (level_mode[1] |=> !flags[1])
        else $error("flag one set in level mode");

    irq_gate_a: assert property (irq_request != 3'h0 |-> global_int_enable)
        else $error("request without global enable");

    level_hold_a: assert property (enables[0] && global_int_enable && level_mode[0]
        && !pin_sync[0] && !power_down |-> irq_request[0])
        else $error("level request missing while pin low");

    stop_edge_a: assert property (io_clk_stopped && !level_mode[0] |=> !$rose(flags[0]))
        else $error("edge caught with I/O clock stopped");

    two_fall_a: assert property ($fell(pin_sync[2]) && !sense_two_edge |=> flags[2])
        else $error("falling edge on input two missed");

    any_change_a: assert property (sense_bits[1:0] == `EPI_MODE_ANY && !io_clk_stopped
        && pin_sync[0] != pin_prev[0] |=> flags[0])
        else $error("change on input zero missed");

    rise_one_a: assert property (sense_bits[3:2] == `EPI_MODE_RISE && !io_clk_stopped
        && !pin_prev[1] && pin_sync[1] ##1 !vector_ack[1] |-> flags[1])
        else $error("rising edge on input one missed");

    wake_sample_a: assert property ($rose(wake_state == WK_STARTUP)
        |-> $past(wdt_tick) && $past(wake_state) == WK_FIRST)
        else $error("start-up entered without second sample");

    wake_end_a: assert property (power_down && wake_state == WK_STARTUP
        && start_cnt == START_LAST |=> wake_up)
        else $error("no wake at end of start-up");

    ack_clear_a: assert property (flags[2] && vector_ack[2] && !trig[2] |=> !flags[2])
        else $error("flag two not cleared by service");

endmodule : epi_top

// File: common/epi_consts.svh
`ifndef EPI_CONSTS_SVH
`define EPI_CONSTS_SVH

// Register byte offsets on the APB bus.
`define EPI_OFF_SENSE_BITS 12'h000
`define EPI_OFF_STATUS_SENSE 12'h004
`define EPI_OFF_ENABLES 12'h008
`define EPI_OFF_FLAGS 12'h00C

// Field positions inside the sense control register.
`define EPI_SENSE_ZERO_LO 0
`define EPI_SENSE_ZERO_HI 1
`define EPI_SENSE_ONE_LO 2
`define EPI_SENSE_ONE_HI 3
// Field position of the input two edge select.
`define EPI_SENSE_TWO_BIT 6
// Enable and flag positions, shared by the enable and flag registers.
`define EPI_BIT_REQ_ONE 7
`define EPI_BIT_REQ_ZERO 6
`define EPI_BIT_REQ_TWO 5

// Sense field encodings for inputs zero and one.
`define EPI_MODE_LOW 2'h0
`define EPI_MODE_ANY 2'h1
`define EPI_MODE_FALL 2'h2
`define EPI_MODE_RISE 2'h3

// Reset values.
`define EPI_RESET_SENSE 4'h0
`define EPI_RESET_ENABLES 3'h0

// Timing: clock period, watchdog oscillator period, minimum pulse on input two.
`define EPI_CLK_PERIOD_NS 10
`define EPI_WDT_PERIOD_NS 1000
`define EPI_WDT_CYCLES (`EPI_WDT_PERIOD_NS / `EPI_CLK_PERIOD_NS)
`define EPI_MIN_PULSE_NS 50
`define EPI_MIN_PULSE_CYCLES (`EPI_MIN_PULSE_NS / `EPI_CLK_PERIOD_NS)

`endif

// File: common/epi_pkg.sv
package epi_pkg;

    // Steps of the power-down level wake-up sequence.
    typedef enum logic [1:0] {
        WK_IDLE,
        WK_FIRST,
        WK_STARTUP
    } epi_wake_e;

    typedef logic [1:0] epi_sense_t;

endpackage : epi_pkg

// File: test/epi_pin_drv.sv
// Far-side model: whatever drives the three request pins.
module epi_pin_drv
(
    input wire logic clk,
    output logic [2:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle pins sit high, so a reset never sees a spurious falling edge.
    initial
    begin
        pin = 3'h7;
    end

    // A new level is launched just after an edge and is held until the next call.
    // Callers wait several cycles so that a low level outlives the instruction in flight.
    task automatic drive(input int idx, input logic v);
        @(posedge clk);
        pin[idx] <= v;
    endtask : drive
endmodule : epi_pin_drv

// File: test/epi_top_tb.sv
`include "epi_consts.svh"

module epi_top_tb import epi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, er;
    logic global_int_enable, io_clk_stopped, power_down, wake_up;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] pins, vector_ack, irq_request;
    int err_count, total_checks, ch, n;
    epi_sense_t mode;

    // A short start-up count keeps the wake sequence to a few hundred cycles.
    epi_top #(.STARTUP_CYCLES(8)) i_epi_top (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_req_pin(pins),
        .global_int_enable(global_int_enable), .vector_ack(vector_ack),
        .io_clk_stopped(io_clk_stopped), .power_down(power_down),
        .irq_request(irq_request), .wake_up(wake_up));
    epi_pin_drv i_epi_pin_drv (.clk(clk), .pin(pins));

    // Free-running 100 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] fmask(input int c);
        return (c == 0) ? 32'h40 : (c == 1) ? 32'h80 : 32'h20;
    endfunction : fmask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc

    // One APB transfer; the wait on pready is open-ended, only the watchdog ends a stuck one.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        w = 0;
        do
        begin
            @(posedge clk);
            w++;
        end
        while (pready !== 1'b1);
        chk(32'(w), 32'h1, "pready wait");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "register read");
    endtask : rdchk

    task automatic conclude();
        $display("Checks made %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    // Cuts a hang short well after the expected run of several hundred cycles.
    initial
    begin
        #500000;
        err_count++;
        conclude();
    end

    // Main sequence: every input gets a value at time zero, reset holds three cycles.
    initial
    begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {vector_ack, io_clk_stopped, power_down} = '0;
        global_int_enable = 1'b1;
        err_count = 0;
        total_checks = 0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        cyc(3);
        rdchk(`EPI_OFF_SENSE_BITS, 32'h0);
        rdchk(`EPI_OFF_ENABLES, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk(32'(er), 32'h1, "unmapped error");
        apb(1'b1, `EPI_OFF_ENABLES, 32'hE0);
        rdchk(`EPI_OFF_ENABLES, 32'hE0);
        $display("Test registers done");
        // Each edge mode of inputs zero and one, checked on both pin edges.
        for (ch = 0; ch < 2; ch++)
            for (n = 1; n < 4; n++)
            begin
                mode = n[1:0];
                apb(1'b1, `EPI_OFF_SENSE_BITS, 32'(mode) << (2 * ch));
                apb(1'b1, `EPI_OFF_FLAGS, 32'hE0);
                i_epi_pin_drv.drive(ch, 1'b0);
                cyc(6);
                chk(32'(irq_request[ch]), 32'(mode != `EPI_MODE_RISE), "irq on fall");
                rdchk(`EPI_OFF_FLAGS, (mode != `EPI_MODE_RISE) ? fmask(ch) : 32'h0);
                apb(1'b1, `EPI_OFF_FLAGS, 32'hE0);
                i_epi_pin_drv.drive(ch, 1'b1);
                cyc(6);
                rdchk(`EPI_OFF_FLAGS, (mode != `EPI_MODE_FALL) ? fmask(ch) : 32'h0);
                apb(1'b1, `EPI_OFF_FLAGS, 32'hE0);
            end
        $display("Test edge modes done");
        // A flag is held while the global enable is off and clears on its vector.
        apb(1'b1, `EPI_OFF_SENSE_BITS, 32'h2);
        global_int_enable <= 1'b0;
        i_epi_pin_drv.drive(0, 1'b0);
        cyc(1);
        i_epi_pin_drv.drive(0, 1'b1);
        cyc(6);
        chk(32'(irq_request), 32'h0, "global enable off");
        global_int_enable <= 1'b1;
        cyc(1);
        chk(32'(irq_request), 32'h1, "own vector only");
        vector_ack <= 3'h1;
        cyc(1);
        vector_ack <= 3'h0;
        cyc(1);
        chk(32'(irq_request), 32'h0, "vector clears");
        // Edges on input zero are ignored while the I/O clock is stopped.
        io_clk_stopped <= 1'b1;
        i_epi_pin_drv.drive(0, 1'b0);
        cyc(4);
        i_epi_pin_drv.drive(0, 1'b1);
        cyc(6);
        io_clk_stopped <= 1'b0;
        rdchk(`EPI_OFF_FLAGS, 32'h0);
        $display("Test gating done");
        // A flag set in fall mode is forced clear once level mode is chosen.
        i_epi_pin_drv.drive(0, 1'b0);
        cyc(6);
        chk(32'(irq_request), 32'h1, "fall flag before level");
        apb(1'b1, `EPI_OFF_SENSE_BITS, 32'h0);
        cyc(14);
        chk(32'(irq_request), 32'h1, "level request");
        rdchk(`EPI_OFF_FLAGS, 32'h0);
        apb(1'b1, `EPI_OFF_ENABLES, 32'hA0);
        cyc(1);
        chk(32'(irq_request), 32'h0, "own enable off");
        apb(1'b1, `EPI_OFF_ENABLES, 32'hE0);
        i_epi_pin_drv.drive(0, 1'b1);
        cyc(4);
        chk(32'(irq_request), 32'h0, "level released");
        $display("Test level done");
        // Input two: each edge select, with the disable, change, clear, enable order.
        for (n = 0; n < 2; n++)
        begin
            apb(1'b1, `EPI_OFF_ENABLES, 32'hC0);
            apb(1'b1, `EPI_OFF_STATUS_SENSE, 32'(n) << `EPI_SENSE_TWO_BIT);
            apb(1'b1, `EPI_OFF_FLAGS, 32'hE0);
            apb(1'b1, `EPI_OFF_ENABLES, 32'hE0);
            i_epi_pin_drv.drive(2, 1'b0);
            cyc(5);
            chk(32'(irq_request), (n == 0) ? 32'h4 : 32'h0, "input two fall");
            i_epi_pin_drv.drive(2, 1'b1);
            cyc(5);
            chk(32'(irq_request), 32'h4, "input two edge");
            vector_ack <= 3'h4;
            cyc(1);
            vector_ack <= 3'h0;
            cyc(1);
            chk(32'(irq_request), 32'h0, "input two vector");
        end
        $display("Test input two done");
        // Power-down wake by a held low level on input zero.
        power_down <= 1'b1;
        i_epi_pin_drv.drive(0, 1'b0);
        cyc(4);
        chk(32'(irq_request), 32'h0, "no request asleep");
        n = 0;
        while (wake_up !== 1'b1 && n < 1000)
        begin
            cyc(1);
            n++;
        end
        chk(32'(n < 1000), 32'h1, "wake pulse");
        power_down <= 1'b0;
        cyc(3);
        chk(32'(irq_request), 32'h1, "request after wake");
        i_epi_pin_drv.drive(0, 1'b1);
        cyc(4);
        // An enabled rising edge on input two wakes the part from power-down.
        power_down <= 1'b1;
        i_epi_pin_drv.drive(2, 1'b0);
        cyc(6);
        i_epi_pin_drv.drive(2, 1'b1);
        cyc(3);
        chk(32'(wake_up), 32'h1, "edge wake on input two");
        power_down <= 1'b0;
        $display("Test wake done");
        conclude();
    end
endmodule : epi_top_tb
